// [bwces_top.sv]
// burst-wrap configuration copies, ecc unit status and burst address stepping
`timescale 1ns/1ps
`default_nettype none
module bwces_top (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic hw_reset_in,
  input wire logic soft_reset_in,
  input wire bwces_pkg::bwces_cmd_s cmd_in,
  input wire bwces_pkg::bwces_rd_start_s rd_start_in,
  input wire logic byte_next_in,
  input wire bwces_pkg::bwces_ecc_upd_s ecc_upd_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [2:0] drive_strength_out,
  output logic wrap_on_out,
  output logic [1:0] wrap_size_out,
  output logic [23:0] read_addr_out,
  output logic wrap_active_out
);

  localparam bwces_pkg::bwces_state_s ST_RESET = '{
    boot: bwces_pkg::BOOT_DEFAULT,
    live: bwces_pkg::BOOT_DEFAULT,
    default: '0
  };

  bwces_pkg::bwces_state_s st;
  bwces_pkg::bwces_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // decoders

  function automatic logic [bwces_pkg::UNIT_BITS-1:0] unit_of(input logic [23:0] a);
    unit_of = a[bwces_pkg::UNIT_SHIFT +: bwces_pkg::UNIT_BITS];
  endfunction

  // 8/16/32/64 byte blocks
  function automatic logic [23:0] wrap_mask(input logic [1:0] len);
    case (len)
      2'b00: wrap_mask = 24'h000007;
      2'b01: wrap_mask = 24'h00000F;
      2'b10: wrap_mask = 24'h00001F;
      2'b11: wrap_mask = 24'h00003F;
      default: wrap_mask = 24'h000007;
    endcase
  endfunction

  function automatic logic is_ecc_read(input logic [7:0] op);
    is_ecc_read = (op == bwces_pkg::OP_ECC_READ_A) || (op == bwces_pkg::OP_ECC_READ_B);
  endfunction

  logic [23:0] cur_mask;
  logic [23:0] addr_inc;
  logic live_wrap_on;
  logic start_wraps;

  assign cur_mask = wrap_mask(st.wlen);
  assign addr_inc = st.raddr + 24'h000001;
  assign live_wrap_on = ~st.live[bwces_pkg::WE_BIT];
  // register and otp reads are flagged as not main array by the decoder
  assign start_wraps = live_wrap_on && rd_start_in.main_array &&
    ((rd_start_in.kind == bwces_pkg::rd_quad_io) ||
     (rd_start_in.kind == bwces_pkg::rd_ddr_quad_io));

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    if (hw_reset_in || soft_reset_in) begin
      // commands in the same cycle are dropped: the reset owns the cycle
      next_st.live = st.boot;
      next_st.ecc = '0;
      next_st.wrap = 1'b0;
      next_st.rdata = 8'h00;
    end else begin
      if (cmd_in.valid) begin
        case (cmd_in.opcode)
          bwces_pkg::OP_READ_ANY: begin
            next_st.rvalid = 1'b1;
            if (cmd_in.addr == bwces_pkg::ADDR_CFG_BOOT) begin
              next_st.rdata = st.boot;
            end else if (cmd_in.addr == bwces_pkg::ADDR_CFG_LIVE) begin
              next_st.rdata = st.live;
            end else begin
              next_st.rdata = 8'h00;
            end
          end
          bwces_pkg::OP_WRITE_ANY: begin
            // nv program time is not modelled; the boot copy updates at once
            if (cmd_in.addr == bwces_pkg::ADDR_CFG_BOOT) begin
              next_st.boot = cmd_in.wdata & ~bwces_pkg::CFG_RSVD_MASK;
            end else if (cmd_in.addr == bwces_pkg::ADDR_CFG_LIVE) begin
              next_st.live = cmd_in.wdata & ~bwces_pkg::CFG_RSVD_MASK;
            end
            // any other address, including ecc status, is left alone
          end
          bwces_pkg::OP_SET_BURST: begin
            // keeps drive strength; only wrap enable and size move
            next_st.live = (st.live & ~bwces_pkg::SBL_MASK) |
              (cmd_in.wdata & bwces_pkg::SBL_MASK);
          end
          default: begin
            if (is_ecc_read(cmd_in.opcode)) begin
              next_st.rvalid = 1'b1;
              next_st.rdata = {bwces_pkg::ECC_RSVD_VALUE, st.ecc[unit_of(cmd_in.addr)]};
            end
          end
        endcase
      end
      // engine overwrites a unit with its latest result; the host cannot
      if (ecc_upd_in.valid) begin
        next_st.ecc[ecc_upd_in.unit] = {ecc_upd_in.code_err, ecc_upd_in.data_err,
          ecc_upd_in.corr_off};
      end
      if (rd_start_in.valid) begin
        next_st.raddr = rd_start_in.addr;
        next_st.wlen = st.live[bwces_pkg::WL_LSB +: 2];
        next_st.wrap = start_wraps;
      end else if (byte_next_in) begin
        if (st.wrap) begin
          next_st.raddr = (st.raddr & ~cur_mask) | (addr_inc & cur_mask);
        end else begin
          next_st.raddr = addr_inc;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st <= ST_RESET;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign rvalid_out = st.rvalid;
  assign drive_strength_out = st.live[bwces_pkg::DS_LSB +: 3];
  assign wrap_on_out = live_wrap_on;
  assign wrap_size_out = st.live[bwces_pkg::WL_LSB +: 2];
  assign read_addr_out = st.raddr;
  assign wrap_active_out = st.wrap;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic go;
  logic any_rst;
  assign go = ce_in && reset_n_in;
  assign any_rst = hw_reset_in || soft_reset_in;

  a_por_defaults: assert property (@(posedge clk_sys_in)
    !reset_n_in |=> (st.boot == 8'h10) && (st.live == 8'h10) && (st.ecc == '0))
    else $error("power-on defaults wrong");

  a_reset_copy: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ce_in && any_rst |=> (st.live == $past(st.boot)) && (drive_strength_out ==
      $past(st.boot[7:5])))
    else $error("reset did not copy boot byte");

  a_drive_update: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == 8'h71) &&
      (cmd_in.addr == bwces_pkg::ADDR_CFG_LIVE)
      |=> drive_strength_out == $past(cmd_in.wdata[7:5]))
    else $error("drive strength not updated");

  a_burst_write: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == 8'hC0)
      |=> (wrap_size_out == $past(cmd_in.wdata[1:0])) &&
        (wrap_on_out == !$past(cmd_in.wdata[4])) &&
        (drive_strength_out == $past(drive_strength_out)))
    else $error("set burst write wrong");

  a_rsvd_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (st.live[3:2] == 2'b00) && (st.boot[3:2] == 2'b00))
    else $error("reserved config bits set");

  a_ecc_answer: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && is_ecc_read(cmd_in.opcode)
      |=> rvalid_out && (rdata_out[2:0] == $past(st.ecc[unit_of(cmd_in.addr)])))
    else $error("ecc status answer wrong");

  a_ecc_readonly: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && !ecc_upd_in.valid |=> st.ecc == $past(st.ecc))
    else $error("ecc status changed without hardware");

  a_seq_step: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && !st.wrap && byte_next_in && !rd_start_in.valid
      |=> read_addr_out == $past(read_addr_out) + 24'h000001)
    else $error("sequential step wrong");

  a_wrap_block: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && st.wrap && byte_next_in && !rd_start_in.valid
      |=> ((read_addr_out & ~$past(cur_mask)) == ($past(read_addr_out) & ~$past(cur_mask)))
        && ((read_addr_out & $past(cur_mask)) == ($past(addr_inc) & $past(cur_mask))))
    else $error("wrap left its block");

  a_other_nowrap: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && rd_start_in.valid &&
      (!rd_start_in.main_array || (rd_start_in.kind == bwces_pkg::rd_other))
      |=> !wrap_active_out)
    else $error("non-array read wraps");

  a_wrap_select: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && rd_start_in.valid && rd_start_in.main_array &&
      (rd_start_in.kind == bwces_pkg::rd_quad_io)
      |=> wrap_active_out == !$past(st.live[4]))
    else $error("wrap enable not honoured");

  a_ddr_select: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && rd_start_in.valid && rd_start_in.main_array &&
      (rd_start_in.kind == bwces_pkg::rd_ddr_quad_io)
      |=> wrap_active_out == !$past(st.live[4]))
    else $error("ddr wrap enable not honoured");

  a_len_latch: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && rd_start_in.valid |=> st.wlen == $past(st.live[1:0]))
    else $error("wrap length not latched");

  a_read_live: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_READ_ANY) &&
      (cmd_in.addr == bwces_pkg::ADDR_CFG_LIVE)
      |=> rvalid_out && (rdata_out == $past(st.live)))
    else $error("live register read wrong");

  a_read_boot: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_READ_ANY) &&
      (cmd_in.addr == bwces_pkg::ADDR_CFG_BOOT)
      |=> rvalid_out && (rdata_out == $past(st.boot)))
    else $error("boot register read wrong");

  a_unmapped_read: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_READ_ANY) &&
      (cmd_in.addr != bwces_pkg::ADDR_CFG_BOOT) && (cmd_in.addr != bwces_pkg::ADDR_CFG_LIVE)
      |=> rvalid_out && (rdata_out == 8'h00))
    else $error("unmapped read not zero");

  a_write_live: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_WRITE_ANY) &&
      (cmd_in.addr == bwces_pkg::ADDR_CFG_LIVE)
      |=> st.live == $past(cmd_in.wdata & ~bwces_pkg::CFG_RSVD_MASK))
    else $error("live register write wrong");

  a_write_boot: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_WRITE_ANY) &&
      (cmd_in.addr == bwces_pkg::ADDR_CFG_BOOT)
      |=> (st.boot == $past(cmd_in.wdata & ~bwces_pkg::CFG_RSVD_MASK)) &&
        (st.live == $past(st.live)))
    else $error("boot register write wrong");

  a_stray_write: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && (cmd_in.opcode == bwces_pkg::OP_WRITE_ANY) &&
      (cmd_in.addr != bwces_pkg::ADDR_CFG_BOOT) && (cmd_in.addr != bwces_pkg::ADDR_CFG_LIVE)
      |=> (st.boot == $past(st.boot)) && (st.live == $past(st.live)))
    else $error("stray write changed a register");

  a_ecc_reserved: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !any_rst && cmd_in.valid && is_ecc_read(cmd_in.opcode)
      |=> rdata_out[7:3] == bwces_pkg::ECC_RSVD_VALUE)
    else $error("ecc reserved bits wrong");

  a_rvalid_reads: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && !(!any_rst && cmd_in.valid &&
      ((cmd_in.opcode == bwces_pkg::OP_READ_ANY) || is_ecc_read(cmd_in.opcode)))
      |=> !rvalid_out)
    else $error("answer without a read");

  a_boot_kept: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && any_rst |=> st.boot == $past(st.boot))
    else $error("reset changed boot copy");

  a_reset_idle: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && any_rst |=> !rvalid_out && !wrap_active_out && (rdata_out == 8'h00))
    else $error("reset left burst or answer");

  ////////////////////////////////////////////////////////////////////////////
  // per-unit status checks

  // an update aims at one unit only; every other unit must hold its value
  for (genvar u = 0; u < bwces_pkg::ECC_UNITS; u++) begin : g_unit_chk
    localparam int UB = bwces_pkg::UNIT_BITS;

    a_unit_hold: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      go && !any_rst && !(ecc_upd_in.valid && (ecc_upd_in.unit == UB'(u)))
        |=> st.ecc[u] == $past(st.ecc[u]))
      else $error("unit status changed without update");

    a_unit_store: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      go && !any_rst && ecc_upd_in.valid && (ecc_upd_in.unit == UB'(u))
        |=> st.ecc[u] == $past({ecc_upd_in.code_err, ecc_upd_in.data_err,
          ecc_upd_in.corr_off}))
      else $error("unit status update lost");

    a_unit_clear: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      go && any_rst |=> st.ecc[u] == 3'h0)
      else $error("unit status not cleared by reset");
  end

  ////////////////////////////////////////////////////////////////////////////
  // coverage

  c_wrap_return: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && st.wrap && byte_next_in && ((st.raddr & cur_mask) == cur_mask));
  c_ecc_flag: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && cmd_in.valid && is_ecc_read(cmd_in.opcode) ##1 rdata_out[1]);
  c_soft_reset: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && soft_reset_in && (st.boot != st.live));
  c_hw_reset: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && hw_reset_in && (st.boot != st.live));
  c_ddr_wrap: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    go && rd_start_in.valid && (rd_start_in.kind == bwces_pkg::rd_ddr_quad_io) ##1 st.wrap);

endmodule // bwces_top
`default_nettype wire

// [bwces_pkg.sv]
// constants and carriers for the burst-wrap configuration and ecc status registers
// Functional notes
// - boot drive-strength field sets live drive strength after every reset kind.
// - host may rewrite live drive strength; it takes effect without reset.
// - boot wrap-enable sets wrap state after reset; 0 wraps, 1 sequential; default 1.
// - only quad io and ddr quad io reads wrap; others stay sequential.
// - boot wrap size 00/01/10/11 gives 8/16/32/64 bytes; default 00.
// - live wrap size sets length and alignment of wrapped reads.
// - live wrap-enable lets the device enter or leave wrap mode at once.
// - live register read by 65h, written by 71h and by C0h.
// - every reset copies the whole boot byte into the live register.
// - register and otp reads never wrap; only main array reads do.
// - opcode 18h or 19h with unit address returns that unit's status.
// - status bit 2 flags a corrected single-bit error in the check code.
// - status bit 1 flags a corrected single-bit error in unit data.
// - status bit 0 flags correction disabled for the unit.
// - status bits default to 0 and only hardware sets them.
// - ecc status is volatile and read-only; host writes never change it.
// - status bits 7 to 3 may read as any value.
`default_nettype none
package bwces_pkg;
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_SET_BURST = 8'hC0;
  localparam logic [7:0] OP_ECC_READ_A = 8'h18;
  localparam logic [7:0] OP_ECC_READ_B = 8'h19;
  localparam logic [23:0] ADDR_CFG_BOOT = 24'h000040;
  localparam logic [23:0] ADDR_CFG_LIVE = 24'h000041;
  localparam int DS_LSB = 5;
  localparam int WE_BIT = 4;
  localparam int WL_LSB = 0;
  localparam logic [7:0] CFG_RSVD_MASK = 8'h0C;
  localparam logic [7:0] SBL_MASK = 8'h13;
  localparam logic [7:0] BOOT_DEFAULT = 8'h10;
  localparam int ECC_UNITS = 16;
  localparam int UNIT_BITS = 4;
  localparam int UNIT_SHIFT = 4;
  localparam logic [4:0] ECC_RSVD_VALUE = 5'h00;

  typedef enum logic [1:0] {
    rd_other = 2'b00,
    rd_quad_io = 2'b01,
    rd_ddr_quad_io = 2'b10
  } bwces_rd_kind_e;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wdata;
  } bwces_cmd_s;

  typedef struct packed {
    logic valid;
    bwces_rd_kind_e kind;
    logic main_array;
    logic [23:0] addr;
  } bwces_rd_start_s;

  typedef struct packed {
    logic valid;
    logic [UNIT_BITS-1:0] unit;
    logic code_err;
    logic data_err;
    logic corr_off;
  } bwces_ecc_upd_s;

  typedef struct packed {
    logic [7:0] boot;
    logic [7:0] live;
    logic [ECC_UNITS-1:0][2:0] ecc;
    logic [7:0] rdata;
    logic rvalid;
    logic [23:0] raddr;
    logic wrap;
    logic [1:0] wlen;
  } bwces_state_s;
endpackage
`default_nettype wire

// [bwces_host_model.sv]
// host-side model issuing decoded register commands
`timescale 1ns/1ps
`default_nettype none
module bwces_host_model (
  input wire logic clk_sys_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output var bwces_pkg::bwces_cmd_s cmd_out
);
  initial cmd_out = '0;
  // one command a pulse; fields scrambled once released
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] wd);
    @(posedge clk_sys_in);
    cmd_out <= '{valid: 1'b1, opcode: op, addr: a, wdata: wd};
    @(posedge clk_sys_in);
    cmd_out <= '{valid: 1'b0, opcode: ~op, addr: ~a, wdata: ~wd};
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] op, input logic [23:0] a, output logic [8:0] rd);
    send(op, a, 8'h00);
    rd = {rvalid_in, rdata_in};
    // status bits 7:3 carry no meaning
    if (op != bwces_pkg::OP_READ_ANY) rd[7:3] = 5'h00;
  endtask
endmodule // bwces_host_model
`default_nettype wire

// [tb_bwces_top.sv]
// self-checking bench for the burst-wrap and ecc status registers
`timescale 1ns/1ps
`default_nettype none
module tb_bwces_top;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1, hw_reset_in = 1'b0, soft_reset_in = 1'b0, byte_next_in = 1'b0;
  bwces_pkg::bwces_cmd_s cmd_in;
  bwces_pkg::bwces_rd_start_s rd_start_in = '0;
  bwces_pkg::bwces_ecc_upd_s ecc_upd_in = '0;
  logic [7:0] rdata_out;
  logic rvalid_out, wrap_on_out, wrap_active_out;
  logic [2:0] drive_strength_out;
  logic [1:0] wrap_size_out;
  logic [23:0] read_addr_out;
  logic [8:0] rd;
  int n_errors = 0, check_count = 0, cycles = 0;
  localparam logic [23:0] LIVE = bwces_pkg::ADDR_CFG_LIVE;
  bwces_top dut_u (.clk_sys_in, .reset_n_in, .ce_in, .hw_reset_in, .soft_reset_in, .cmd_in,
    .rd_start_in, .byte_next_in, .ecc_upd_in, .rdata_out, .rvalid_out, .drive_strength_out,
    .wrap_on_out, .wrap_size_out, .read_addr_out, .wrap_active_out);
  bwces_host_model host_u (.clk_sys_in, .rvalid_in(rvalid_out), .rdata_in(rdata_out),
    .cmd_out(cmd_in));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // runs take about 100 cycles; a hang stops far beyond
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input logic hw);
    @(posedge clk_sys_in);
    hw_reset_in <= hw;
    soft_reset_in <= !hw;
    @(posedge clk_sys_in);
    hw_reset_in <= 1'b0;
    soft_reset_in <= 1'b0;
    #1;
  endtask
  task automatic start(input bwces_pkg::bwces_rd_kind_e k, input logic m, input logic [23:0] a,
      input logic act);
    @(posedge clk_sys_in);
    rd_start_in <= '{valid: 1'b1, kind: k, main_array: m, addr: a};
    @(posedge clk_sys_in);
    rd_start_in.valid <= 1'b0;
    #1;
    chk("read_addr", a, read_addr_out);
    chk("wrap_active", act, wrap_active_out);
  endtask
  task automatic step(input logic [23:0] a);
    @(posedge clk_sys_in);
    byte_next_in <= 1'b1;
    @(posedge clk_sys_in);
    byte_next_in <= 1'b0;
    #1;
    chk("read_addr", a, read_addr_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    chk("drive", 24'h0, drive_strength_out);
    chk("wrap_on", 24'h0, wrap_on_out);
    chk("wrap_size", 24'h0, wrap_size_out);
    host_u.rd_reg(8'h65, LIVE, rd);
    chk("live", 24'h110, rd);
    $display("test reset done");
  endtask
  task automatic t_live;
    host_u.send(8'h71, LIVE, 8'hA5);
    chk("drive", 24'h5, drive_strength_out);
    chk("wrap_on", 24'h1, wrap_on_out);
    chk("wrap_size", 24'h1, wrap_size_out);
    host_u.rd_reg(8'h65, LIVE, rd);
    chk("live", 24'h1A1, rd);
    host_u.send(8'hC0, 24'h0, 8'h13);
    host_u.rd_reg(8'h65, LIVE, rd);
    chk("live", 24'h1B3, rd);
    host_u.rd_reg(8'h65, 24'h000055, rd);
    chk("unmapped", 24'h100, rd);
    $display("test live done");
  endtask
  task automatic t_boot;
    host_u.send(8'h71, bwces_pkg::ADDR_CFG_BOOT, 8'hE6);
    host_u.rd_reg(8'h65, bwces_pkg::ADDR_CFG_BOOT, rd);
    chk("boot", 24'h1E2, rd);
    chk("wrap_size", 24'h3, wrap_size_out);
    pulse(1'b0);
    chk("drive", 24'h7, drive_strength_out);
    chk("wrap_on", 24'h1, wrap_on_out);
    chk("wrap_size", 24'h2, wrap_size_out);
    host_u.send(8'h71, LIVE, 8'h00);
    pulse(1'b1);
    host_u.rd_reg(8'h65, LIVE, rd);
    chk("live", 24'h1E2, rd);
    $display("test boot done");
  endtask
  task automatic t_ecc;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_in);
      ecc_upd_in <= '{valid: 1'b1, unit: 4'(i * 5 + 2), code_err: i == 0, data_err: i == 1,
        corr_off: i == 2};
      @(posedge clk_sys_in);
      ecc_upd_in.valid <= 1'b0;
      host_u.rd_reg((i == 1) ? 8'h19 : 8'h18, {16'h0, 4'(i * 5 + 2), 4'h0}, rd);
      chk("ecc", 24'h100 | (24'h4 >> i), rd);
    end
    host_u.send(8'h71, 24'h000020, 8'hFF);
    host_u.rd_reg(8'h18, 24'h000020, rd);
    chk("ecc", 24'h104, rd);
    host_u.rd_reg(8'h18, 24'h000000, rd);
    chk("ecc", 24'h100, rd);
    pulse(1'b0);
    host_u.rd_reg(8'h18, 24'h000070, rd);
    chk("ecc", 24'h100, rd);
    $display("test ecc done");
  endtask
  task automatic t_burst;
    host_u.send(8'h71, LIVE, 8'h00);
    start(bwces_pkg::rd_quad_io, 1'b1, 24'h000006, 1'b1);
    for (int i = 0; i < 3; i++) step(24'((7 + i) % 8));
    start(bwces_pkg::rd_other, 1'b1, 24'h000006, 1'b0);
    step(24'h000007);
    start(bwces_pkg::rd_quad_io, 1'b0, 24'h000006, 1'b0);
    host_u.send(8'h71, LIVE, 8'h01);
    start(bwces_pkg::rd_ddr_quad_io, 1'b1, 24'h00000E, 1'b1);
    for (int i = 0; i < 2; i++) step(24'((15 + i) % 16));
    $display("test burst done");
  endtask
  // a write while the enable is low must be lost, the same write after it lands
  task automatic t_ce;
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    host_u.send(8'h71, LIVE, 8'hE0);
    chk("drive", 24'h0, drive_strength_out);
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    host_u.send(8'h71, LIVE, 8'hE0);
    chk("drive", 24'h7, drive_strength_out);
    $display("test ce done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_live();
    t_boot();
    t_ecc();
    t_burst();
    t_ce();
    results();
  end
endmodule // tb_bwces_top
`default_nettype wire
